// File: rtl/tcx_timer.sv
// What this block does
// - two 8-bit timers, or chained 16-bit
// - timer 2 uses internal clocks only
// - internal clock periods 2, 32, 512 instructions
// - external clock only for timer 1
// - counter counts rising external edges
// - counter match raises interrupt, inverts output
// - timer 1 interval match toggles square-wave output
// - interval is clock period times compare+1
// - 16-bit interval 1 to 65536 clocks
// - 8-bit counter counts up to 256 edges
// - 16-bit counter counts up to 65536 edges
// - timer matches clock the PWM timers
// - timer 1 match triggers A/D converter
// - match clears counter, reloads comparison latch
// - clock select codes 00,01,10,11 external
// - run clears and starts; pause holds count
// - output control port, preset low/high, drive
`timescale 1ns/10ps
`include "tcx_cfg.svh"
module tcx_timer
    import tcx_pkg::*;
#(
    parameter int CYC_PER_TINST = `TCX_CYC_PER_TINST
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic mode16,
    input wire logic runBit1,
    input wire logic pauseBit1,
    input wire tcx_sel_type countClockSelect1,
    input wire tcx_sel_type outputControlField,
    input wire logic intEnable1,
    input wire logic flagClear1,
    input wire tcx_byte_type timer1CompareValue,
    input wire logic runBit2,
    input wire logic pauseBit2,
    input wire tcx_sel_type countClockSelect2,
    input wire logic intEnable2,
    input wire logic flagClear2,
    input wire tcx_byte_type timer2CompareValue,
    input wire logic extCountInPin,
    output logic squareWaveOutPin,
    output logic squareWaveOutEn,
    output logic intFlag1,
    output logic intFlag2,
    output logic intReq,
    output tcx_byte_type count1,
    output tcx_byte_type count2,
    output logic pwm1CountClk,
    output logic pwm2CountClk,
    output logic adcTrigger
);
    localparam int TINST_W = (CYC_PER_TINST > 1) ? $clog2(CYC_PER_TINST) : 1;
    localparam int DIV_A_MSB = $clog2(`TCX_PER_A_TINST) - 1;
    localparam int DIV_B_MSB = $clog2(`TCX_PER_B_TINST) - 1;
    localparam int DIV_C_MSB = $clog2(`TCX_PER_C_TINST) - 1;

    if (CYC_PER_TINST < 1) begin : g_bad_cyc
        $error("CYC_PER_TINST must be at least one");
    end

    // ------------------------------------------------------------------
    // instruction-cycle pulse and prescaler
    // ------------------------------------------------------------------
    logic [TINST_W-1:0] tinstCnt_ff;
    logic [`TCX_PRESC_W-1:0] presc_ff;
    logic tinstPulse;

    assign tinstPulse = (tinstCnt_ff == TINST_W'(CYC_PER_TINST - 1));

    always_ff @(posedge clk) begin
        if (srst || tinstPulse) begin
            tinstCnt_ff <= '0;
        end else begin
            tinstCnt_ff <= tinstCnt_ff + TINST_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            presc_ff <= `TCX_PRESC_ZERO;
        end else if (tinstPulse) begin
            presc_ff <= presc_ff + `TCX_PRESC_W'(1);
        end
    end

    // one count-clock tick for the selected internal period
    function automatic logic intTick(input tcx_sel_type sel,
                                     input logic [`TCX_PRESC_W-1:0] p);
        case (sel)
            `TCX_CS_2: intTick = &p[DIV_A_MSB:0];
            `TCX_CS_32: intTick = &p[DIV_B_MSB:0];
            `TCX_CS_512: intTick = &p[DIV_C_MSB:0];
            default: intTick = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // external count input
    // ------------------------------------------------------------------
    logic extSync1_ff;
    logic extSync2_ff;
    logic extPrev_ff;
    logic extRise;

    always_ff @(posedge clk) begin
        if (srst) begin
            extSync1_ff <= 1'b0;
            extSync2_ff <= 1'b0;
            extPrev_ff <= 1'b0;
        end else begin
            extSync1_ff <= extCountInPin;
            extSync2_ff <= extSync1_ff;
            extPrev_ff <= extSync2_ff;
        end
    end

    assign extRise = extSync2_ff && !extPrev_ff;

    // ------------------------------------------------------------------
    // run edge detection
    // ------------------------------------------------------------------
    logic run1Prev_ff;
    logic run2Prev_ff;
    logic start1;
    logic start2;

    always_ff @(posedge clk) begin
        if (srst) begin
            run1Prev_ff <= 1'b0;
            run2Prev_ff <= 1'b0;
        end else begin
            run1Prev_ff <= runBit1;
            run2Prev_ff <= runBit2;
        end
    end

    assign start1 = runBit1 && !run1Prev_ff;
    assign start2 = runBit2 && !run2Prev_ff && !mode16;

    // ------------------------------------------------------------------
    // count ticks and compare
    // ------------------------------------------------------------------
    tcx_ctr_if ctr1 ();
    tcx_ctr_if ctr2 ();

    logic tick1;
    logic tick2;
    logic match1;
    logic match2;
    logic match16;
    logic lowMatch;

    always_comb begin
        tick1 = 1'b0;
        if (runBit1 && !pauseBit1 && !start1) begin
            if (countClockSelect1 == `TCX_CS_EXT) begin
                tick1 = extRise;
            end else begin
                tick1 = tinstPulse && intTick(countClockSelect1, presc_ff);
            end
        end
    end

    // timer 2 never sees the external clock
    assign tick2 = runBit2 && !pauseBit2 && !start2 && !mode16
                   && tinstPulse && intTick(countClockSelect2, presc_ff);

    assign lowMatch = (ctr1.cnt == ctr1.latch);
    assign match16 = mode16 && tick1 && lowMatch
                     && (ctr2.cnt == ctr2.latch);
    assign match1 = mode16 ? match16 : (tick1 && lowMatch);
    assign match2 = tick2 && (ctr2.cnt == ctr2.latch);

    always_comb begin
        ctr1.dataReg = timer1CompareValue;
        ctr2.dataReg = timer2CompareValue;
        ctr1.load = start1 || match1;
        ctr1.inc = tick1 && !match1;
        if (mode16) begin
            ctr2.load = start1 || match16;
            ctr2.inc = tick1 && !match16 && (ctr1.cnt == `TCX_BYTE_FULL);
        end else begin
            ctr2.load = start2 || match2;
            ctr2.inc = tick2 && !match2;
        end
    end

    tcx_counter #(
        .WIDTH(8)
    ) u_ctr1 (
        .clk(clk),
        .srst(srst),
        .port(ctr1.ctr)
    );

    tcx_counter #(
        .WIDTH(8)
    ) u_ctr2 (
        .clk(clk),
        .srst(srst),
        .port(ctr2.ctr)
    );

    // ------------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            intFlag1 <= 1'b0;
        end else if (match1) begin
            intFlag1 <= 1'b1;
        end else if (flagClear1) begin
            intFlag1 <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            intFlag2 <= 1'b0;
        end else if (match2) begin
            intFlag2 <= 1'b1;
        end else if (flagClear2) begin
            intFlag2 <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            intReq <= 1'b0;
        end else begin
            intReq <= (intFlag1 && intEnable1) || (intFlag2 && intEnable2);
        end
    end

    // ------------------------------------------------------------------
    // square-wave output
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            squareWaveOutPin <= 1'b0;
        end else if (!runBit1) begin
            if (outputControlField == `TCX_OC_PRESET_LO) begin
                squareWaveOutPin <= 1'b0;
            end else if (outputControlField == `TCX_OC_PRESET_HI) begin
                squareWaveOutPin <= 1'b1;
            end
        end else if (match1 && outputControlField == `TCX_OC_DRIVE) begin
            squareWaveOutPin <= !squareWaveOutPin;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            squareWaveOutEn <= 1'b0;
        end else begin
            squareWaveOutEn <= (outputControlField != `TCX_OC_PORT);
        end
    end

    // ------------------------------------------------------------------
    // match outputs to other blocks and count readback
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm1CountClk <= 1'b0;
            pwm2CountClk <= 1'b0;
            adcTrigger <= 1'b0;
        end else begin
            pwm1CountClk <= match1;
            pwm2CountClk <= mode16 ? match16 : match2;
            adcTrigger <= match1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count1 <= `TCX_BYTE_ZERO;
            count2 <= `TCX_BYTE_ZERO;
        end else begin
            count1 <= ctr1.cnt;
            count2 <= ctr2.cnt;
        end
    end
endmodule // tcx_timer

// File: rtl/tcx_cfg.svh
`ifndef TCX_CFG_SVH
`define TCX_CFG_SVH

// ----------------------------------------------------------------------
// count clock select codes
// ----------------------------------------------------------------------
`define TCX_CS_2 2'h0
`define TCX_CS_32 2'h1
`define TCX_CS_512 2'h2
`define TCX_CS_EXT 2'h3

// ----------------------------------------------------------------------
// output control codes
// ----------------------------------------------------------------------
`define TCX_OC_PORT 2'h0
`define TCX_OC_PRESET_LO 2'h1
`define TCX_OC_PRESET_HI 2'h2
`define TCX_OC_DRIVE 2'h3

// ----------------------------------------------------------------------
// timing, in instruction cycles
// ----------------------------------------------------------------------
`define TCX_CYC_PER_TINST 1
`define TCX_PER_A_TINST 2
`define TCX_PER_B_TINST 32
`define TCX_PER_C_TINST 512
`define TCX_PRESC_W 9

// ----------------------------------------------------------------------
// reset values and full-byte constant
// ----------------------------------------------------------------------
`define TCX_BYTE_ZERO 8'h00
`define TCX_BYTE_FULL 8'hff
`define TCX_PRESC_ZERO 9'h000

`endif

// File: rtl/tcx_pkg.sv
package tcx_pkg;
    typedef logic [7:0] tcx_byte_type;
    typedef logic [1:0] tcx_sel_type;
    typedef logic [15:0] tcx_word_type;
endpackage

// File: rtl/tcx_ctr_if.sv
`timescale 1ns/10ps
interface tcx_ctr_if;
    import tcx_pkg::*;
    logic inc;
    logic load;
    tcx_byte_type dataReg;
    tcx_byte_type cnt;
    tcx_byte_type latch;
    modport ctl (output inc, output load, output dataReg, input cnt, input latch);
    modport ctr (input inc, input load, input dataReg, output cnt, output latch);
endinterface // tcx_ctr_if

// File: rtl/tcx_counter.sv
`timescale 1ns/10ps
`include "tcx_cfg.svh"
module tcx_counter
    import tcx_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    tcx_ctr_if.ctr port
);
    if (WIDTH != 8) begin : g_bad_width
        $error("tcx_counter serves only 8-bit counter circuits");
    end

    // ------------------------------------------------------------------
    // counter and comparison latch
    // ------------------------------------------------------------------
    tcx_byte_type cnt_ff;
    tcx_byte_type latch_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= `TCX_BYTE_ZERO;
        end else if (port.load) begin
            cnt_ff <= `TCX_BYTE_ZERO;
        end else if (port.inc) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latch_ff <= `TCX_BYTE_ZERO;
        end else if (port.load) begin
            latch_ff <= port.dataReg;
        end
    end

    assign port.cnt = cnt_ff;
    assign port.latch = latch_ff;
endmodule // tcx_counter

// File: testbench/tcx_ext_src.sv
`timescale 1ns/10ps
module tcx_ext_src #(
    parameter int HALF_NS = 120
) (
    input wire logic en,
    output logic pin
);
    // idle low, steady edges while enabled
    always begin
        pin = 1'b0;
        wait (en);
        while (en) begin
            #HALF_NS pin = 1'b1;
            #HALF_NS pin = 1'b0;
        end
    end
endmodule // tcx_ext_src

// File: testbench/tcx_timer_assertions.sv
`timescale 1ns/10ps
module tcx_timer_assertions
    import tcx_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic mode16,
    input wire logic runBit1,
    input wire tcx_sel_type outputControlField,
    input wire logic intEnable1,
    input wire logic intEnable2,
    input wire logic flagClear1,
    input wire logic squareWaveOutPin,
    input wire logic squareWaveOutEn,
    input wire logic intFlag1,
    input wire logic intFlag2,
    input wire logic intReq,
    input wire logic pwm1CountClk,
    input wire logic pwm2CountClk,
    input wire logic adcTrigger
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence presetLo;
        (outputControlField == 2'h1 && !runBit1) [*2];
    endsequence
    sequence presetHi;
        (outputControlField == 2'h2 && !runBit1) [*2];
    endsequence
    chk_adc_follow: assert property (adcTrigger == pwm1CountClk)
        else $error("adc trigger differs");
    chk_pulse_single: assert property (pwm1CountClk |=> !pwm1CountClk)
        else $error("match pulse too long");
    chk_flag1_set: assert property (pwm1CountClk |-> intFlag1)
        else $error("flag1 not set");
    chk_flag2_set: assert property (pwm2CountClk && !mode16 |-> intFlag2)
        else $error("flag2 not set");
    chk_flag_holds: assert property (intFlag1 && !flagClear1 |=> intFlag1)
        else $error("flag1 dropped");
    chk_flag_clears: assert property (flagClear1 |=> !intFlag1 || pwm1CountClk)
        else $error("flag1 not cleared");
    chk_req_gate: assert property (!$past(srst) |->
        intReq == $past(intFlag1 && intEnable1 || intFlag2 && intEnable2))
        else $error("request gating wrong");
    chk_pin_enable: assert property (!$past(srst) |->
        squareWaveOutEn == ($past(outputControlField) != 2'h0))
        else $error("pin enable wrong");
    chk_preset_lo: assert property (presetLo |-> !squareWaveOutPin)
        else $error("preset low failed");
    chk_preset_hi: assert property (presetHi |-> squareWaveOutPin)
        else $error("preset high failed");
    chk_sq_toggle: assert property (outputControlField == 2'h3 && !$past(srst)
        && $past(outputControlField) == 2'h3
        |-> $changed(squareWaveOutPin) == pwm1CountClk)
        else $error("square toggle wrong");
    chk_chain_pwm: assert property (mode16 && $past(mode16) && $past(mode16, 2)
        |-> pwm2CountClk == pwm1CountClk)
        else $error("chained pwm clocks differ");
endmodule // tcx_timer_assertions

bind tcx_timer tcx_timer_assertions u_chk (
    .clk(clk),
    .srst(srst),
    .mode16(mode16),
    .runBit1(runBit1),
    .outputControlField(outputControlField),
    .intEnable1(intEnable1),
    .intEnable2(intEnable2),
    .flagClear1(flagClear1),
    .squareWaveOutPin(squareWaveOutPin),
    .squareWaveOutEn(squareWaveOutEn),
    .intFlag1(intFlag1),
    .intFlag2(intFlag2),
    .intReq(intReq),
    .pwm1CountClk(pwm1CountClk),
    .pwm2CountClk(pwm2CountClk),
    .adcTrigger(adcTrigger)
);

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench
    import tcx_pkg::*;
;
    logic clk = 0, srst = 1, mode16 = 0, runBit1 = 0, pauseBit1 = 0, intEnable1 = 0;
    logic flagClear1 = 0, runBit2 = 0, pauseBit2 = 0, intEnable2 = 0, flagClear2 = 0;
    logic extEn = 0, extCountInPin, squareWaveOutPin, squareWaveOutEn;
    logic intFlag1, intFlag2, intReq, pwm1CountClk, pwm2CountClk, adcTrigger;
    tcx_sel_type countClockSelect1 = 2'h0, countClockSelect2 = 2'h0;
    tcx_sel_type outputControlField = 2'h0;
    tcx_byte_type timer1CompareValue = 8'h00, timer2CompareValue = 8'h00, count1, count2;
    int errors = 0, n_checks = 0;
    logic [7:0] lf = 8'h03;

    always #20 clk = ~clk;
    tcx_timer u_dut (
        .clk(clk),
        .srst(srst),
        .mode16(mode16),
        .runBit1(runBit1),
        .pauseBit1(pauseBit1),
        .countClockSelect1(countClockSelect1),
        .outputControlField(outputControlField),
        .intEnable1(intEnable1),
        .flagClear1(flagClear1),
        .timer1CompareValue(timer1CompareValue),
        .runBit2(runBit2),
        .pauseBit2(pauseBit2),
        .countClockSelect2(countClockSelect2),
        .intEnable2(intEnable2),
        .flagClear2(flagClear2),
        .timer2CompareValue(timer2CompareValue),
        .extCountInPin(extCountInPin),
        .squareWaveOutPin(squareWaveOutPin),
        .squareWaveOutEn(squareWaveOutEn),
        .intFlag1(intFlag1),
        .intFlag2(intFlag2),
        .intReq(intReq),
        .count1(count1),
        .count2(count2),
        .pwm1CountClk(pwm1CountClk),
        .pwm2CountClk(pwm2CountClk),
        .adcTrigger(adcTrigger)
    );
    tcx_ext_src u_src (.en(extEn), .pin(extCountInPin));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] step(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // external source period is 6 clocks
    function automatic int expIv(input tcx_sel_type s, input int v);
        return (v + 1) * (s == 2'h0 ? 2 : s == 2'h1 ? 32 : s == 2'h2 ? 512 : 6);
    endfunction
    function automatic logic pls(input bit t2);
        return t2 ? pwm2CountClk : pwm1CountClk;
    endfunction
    task automatic ck(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // restart one timer, time the gap between two matches
    task automatic go(input bit t2, input tcx_sel_type s, input int v, input int e);
        int n;
        logic sq;
        runBit1 = 0;
        runBit2 = 0;
        intEnable1 = lf[1];
        intEnable2 = lf[2];
        @(negedge clk);
        flagClear1 = 1;
        flagClear2 = 1;
        if (t2) countClockSelect2 = s;
        else countClockSelect1 = s;
        {timer2CompareValue, timer1CompareValue} = t2 ? {v[7:0], 8'h00} : v[15:0];
        runBit1 = !t2;
        runBit2 = t2;
        @(negedge clk);
        flagClear1 = 0;
        flagClear2 = 0;
        n = 0;
        while (pls(t2) !== 1'b1 && n < 70000) begin
            @(negedge clk);
            n++;
        end
        sq = squareWaveOutPin;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pls(t2) !== 1'b1 && n < 70000);
        ck(n == e, "interval length");
        ck({mode16 ? count2 : 8'h00, t2 ? count2 : count1} === v, "count at match");
        ck((t2 ? intFlag2 : intFlag1) === 1'b1, "flag not set");
        ck((squareWaveOutPin !== sq) == !t2, "square level");
        @(negedge clk);
        ck(intReq === (t2 ? intEnable2 : intEnable1), "request gate");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        tcx_sel_type s;
        int v, n;
        tcx_byte_type c;
        repeat (16) @(negedge clk);
        srst = 0;
        @(negedge clk);
        for (int f = 1; f < 4; f++) begin
            outputControlField = f[1:0];
            repeat (2) @(negedge clk);
            ck(squareWaveOutEn === 1'b1 && (f == 3 || squareWaveOutPin === f[1]), "preset");
        end
        for (int i = 0; i < 6; i++) begin
            lf = step(lf);
            s = tcx_sel_type'(i % 3);
            v = (i % 3 == 2) ? lf[0] : (i % 3 == 1) ? lf[5:0] : lf;
            go(i > 2, s, v, expIv(s, v));
        end
        extEn = 1;
        go(0, 2'h0, 0, expIv(2'h0, 0));
        go(0, 2'h3, 0, expIv(2'h3, 0));
        timer1CompareValue = 8'h01;
        n = 1;
        while (pwm1CountClk !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        ck(n == expIv(2'h3, 0), "old compare value not kept");
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pwm1CountClk !== 1'b1 && n < 100);
        ck(n == expIv(2'h3, 1), "new compare value not taken");
        go(0, 2'h3, 255, expIv(2'h3, 255));
        pauseBit1 = 1;
        repeat (2) @(negedge clk);
        c = count1;
        repeat (20) @(negedge clk);
        ck(count1 === c, "count moved in pause");
        pauseBit1 = 0;
        repeat (20) @(negedge clk);
        ck(count1 !== c, "count stuck after pause");
        mode16 = 1;
        lf = step(lf);
        go(0, 2'h0, {8'h01, lf}, expIv(2'h0, {8'h01, lf}));
        go(0, 2'h3, {8'h01, lf}, expIv(2'h3, {8'h01, lf}));
        runBit1 = 0;
        @(negedge clk);
        mode16 = 0;
        countClockSelect2 = 2'h3;
        runBit2 = 1;
        n = 0;
        repeat (300) begin
            @(negedge clk);
            n += (pwm2CountClk === 1'b1);
        end
        ck(n == 0, "timer2 counted external");
        print_verdict();
    end

    initial begin
        #2400000;
        errors++;
        print_verdict();
    end
endmodule // testbench
